// file: rtl/csu_clock_source_unit.sv
/*
  Clock source unit: reference select, reference divider, frequency-locked
  loop with bypass, bus frequency divider, bus clock, low-power oscillator
  and gated reference outputs. All clocks are produced as sampled levels
  on clk_sys; reference pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module csu_clock_source_unit #(
  parameter int unsigned LPO_HALF = csu_pkg::LPO_HALF_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ext_ref_pin,
  input  wire logic         int_ref_pin,
  input  wire logic         stop_mode,
  input  wire csu_pkg::csu_cfg_t cfg,
  output csu_pkg::csu_clk_t clk_out,
  output logic              loop_ref_external
);
  import csu_pkg::*;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_OLD_LOW,
    SW_NEW_LOW
  } csu_sw_t;

  // Half of an edge-counting divide, rounded up for odd factors
  function automatic logic [REFERENCE_DIVIDER_W-1:0] half_up(input logic [REFERENCE_DIVIDER_W-1:0] n);
    half_up = REFERENCE_DIVIDER_W'((n + 1'b1) >> 1);
  endfunction : half_up

  function automatic logic [3:0] bus_frequency_divider_factor(input csu_bus_frequency_divider_t b);
    case (b)
      BUS_FREQUENCY_DIVIDER_1:  bus_frequency_divider_factor = 4'h1;
      BUS_FREQUENCY_DIVIDER_2:  bus_frequency_divider_factor = 4'h2;
      BUS_FREQUENCY_DIVIDER_4:  bus_frequency_divider_factor = 4'h4;
      default: bus_frequency_divider_factor = 4'h8;
    endcase
  endfunction : bus_frequency_divider_factor

  // Three-stage synchronisers; the third stage and its delayed copy (ext_d_reg, int_d_reg) are read
  logic [1:0] ext_s1_reg, int_s1_reg;
  logic       ext_s2_reg, int_s2_reg, ext_d_reg, int_d_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext_s1_reg <= 2'h0;
      int_s1_reg <= 2'h0;
      ext_s2_reg <= 1'b0;
      int_s2_reg <= 1'b0;
      ext_d_reg  <= 1'b0;
      int_d_reg  <= 1'b0;
    end else begin
      ext_s1_reg <= {ext_s1_reg[0], ext_ref_pin};
      int_s1_reg <= {int_s1_reg[0], int_ref_pin};
      ext_s2_reg <= ext_s1_reg[1];
      int_s2_reg <= int_s1_reg[1];
      ext_d_reg  <= ext_s2_reg;
      int_d_reg  <= int_s2_reg;
    end
  end

  wire ext_rise = ext_s2_reg & ~ext_d_reg;

  // Reference divider, loop, bypass switch, bus divider, outputs
  logic [REFERENCE_DIVIDER_W-1:0] reference_divider_cnt_reg, reference_divider_cnt_next, reference_divider_n_reg, reference_divider_n_next;
  logic              reference_divider_out_reg, reference_divider_out_next;
  logic              ref_ext_reg, ref_ext_next;
  logic              loop_in_reg, loop_in_next, loop_in_d_reg;
  logic [PER_W-1:0]  per_cnt_reg, per_cnt_next, per_reg, per_next;
  logic [PER_W-1:0]  acc_reg, acc_next;
  logic              fll_reg, fll_next;
  csu_sw_t           sw_reg, sw_next;
  logic              byp_cur_reg, byp_cur_next;
  logic              mux_reg, mux_next, mux_d_reg;
  logic [3:0]        bcnt_reg, bcnt_next, bn_reg, bn_next;
  logic              cso_reg, cso_next, bus_reg, bus_next;
  logic              irc_gate_reg, irc_gate_next, erc_gate_reg, erc_gate_next;
  logic [LPO_W-1:0]  lpo_cnt_reg, lpo_cnt_next;
  logic              lpo_reg, lpo_next;
  csu_clk_t          out_next;

  always_comb begin
    logic [REFERENCE_DIVIDER_W-1:0] n_req;
    n_req = (cfg.ref_divider == '0) ? REFERENCE_DIVIDER_RESET :
            (cfg.ref_divider > REFERENCE_DIVIDER_W'(REFERENCE_DIVIDER_MAX)) ? REFERENCE_DIVIDER_W'(REFERENCE_DIVIDER_MAX) : cfg.ref_divider;
    // Reference divider counts external edges; new factor taken at wrap
    reference_divider_cnt_next = reference_divider_cnt_reg;
    reference_divider_n_next   = reference_divider_n_reg;
    if (ext_rise) begin
      if (reference_divider_cnt_reg >= reference_divider_n_reg - 1'b1) begin
        reference_divider_cnt_next = '0;
        reference_divider_n_next   = n_req;
      end else begin
        reference_divider_cnt_next = reference_divider_cnt_reg + 1'b1;
      end
    end
    reference_divider_out_next = (reference_divider_n_reg == REFERENCE_DIVIDER_RESET) ? ext_s2_reg :
                    (reference_divider_cnt_next < half_up(reference_divider_n_reg));
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reference_divider_cnt_reg <= '0;
      reference_divider_n_reg   <= REFERENCE_DIVIDER_RESET;
      reference_divider_out_reg <= 1'b0;
    end else begin
      reference_divider_cnt_reg <= reference_divider_cnt_next;
      reference_divider_n_reg   <= reference_divider_n_next;
      reference_divider_out_reg <= reference_divider_out_next;
    end
  end

  always_comb begin
    logic [PER_W:0] sum;
    sum = {1'b0, acc_reg} + {(PER_W - MULT_W)'(0), cfg.loop_mult, 1'b0};
    // Source change only while both candidates are low
    ref_ext_next = ref_ext_reg;
    if (cfg.ref_external != ref_ext_reg && !reference_divider_out_reg && !int_s2_reg)
      ref_ext_next = cfg.ref_external;
    loop_in_next = ref_ext_reg ? reference_divider_out_reg : int_s2_reg;
    // Loop: measure input period, phase accumulator at mult x input
    per_cnt_next = (per_cnt_reg == '1) ? per_cnt_reg : per_cnt_reg + 1'b1;
    per_next     = per_reg;
    if (loop_in_reg && !loop_in_d_reg) begin
      per_next     = per_cnt_reg + 1'b1;
      per_cnt_next = '0;
    end
    acc_next = sum[PER_W-1:0];
    fll_next = fll_reg;
    if (per_reg == '0) begin
      acc_next = '0;
    end else if (sum >= {1'b0, per_reg}) begin
      acc_next = PER_W'(sum - {1'b0, per_reg});
      if (acc_next >= per_reg)
        acc_next = '0;
      fll_next = ~fll_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_ext_reg   <= 1'b0;
      loop_in_reg   <= 1'b0;
      loop_in_d_reg <= 1'b0;
      per_cnt_reg   <= '0;
      per_reg       <= '0;
      acc_reg       <= '0;
      fll_reg       <= 1'b0;
    end else begin
      ref_ext_reg   <= ref_ext_next;
      loop_in_reg   <= loop_in_next;
      loop_in_d_reg <= loop_in_reg;
      per_cnt_reg   <= per_cnt_next;
      per_reg       <= per_next;
      acc_reg       <= acc_next;
      fll_reg       <= fll_next;
    end
  end

  always_comb begin
    logic want_byp, old_src, new_src;
    // Glitch-free bypass switch
    want_byp     = cfg.loop_bypass;
    old_src      = byp_cur_reg ? loop_in_reg : fll_reg;
    new_src      = want_byp ? loop_in_reg : fll_reg;
    sw_next      = sw_reg;
    byp_cur_next = byp_cur_reg;
    mux_next     = 1'b0;
    case (sw_reg)
      SW_RUN: begin
        mux_next = old_src;
        if (want_byp != byp_cur_reg)
          sw_next = SW_OLD_LOW;
      end
      SW_OLD_LOW: begin
        mux_next = old_src;
        if (!old_src) begin
          mux_next = 1'b0;
          sw_next  = SW_NEW_LOW;
        end
      end
      SW_NEW_LOW: begin
        if (!new_src) begin
          byp_cur_next = want_byp;
          sw_next      = SW_RUN;
        end
      end
      default: sw_next = SW_RUN;
    endcase
    if (stop_mode)
      mux_next = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_reg      <= SW_RUN;
      byp_cur_reg <= 1'b0;
      mux_reg     <= 1'b0;
      mux_d_reg   <= 1'b0;
    end else begin
      sw_reg      <= sw_next;
      byp_cur_reg <= byp_cur_next;
      mux_reg     <= mux_next;
      mux_d_reg   <= mux_reg;
    end
  end

  always_comb begin
    // Bus frequency divider on mux edges; factor taken at wrap
    bcnt_next = bcnt_reg;
    bn_next   = bn_reg;
    if (mux_reg && !mux_d_reg) begin
      if (bcnt_reg >= bn_reg - 1'b1) begin
        bcnt_next = '0;
        bn_next   = bus_frequency_divider_factor(cfg.bus_divider);
      end else begin
        bcnt_next = bcnt_reg + 1'b1;
      end
    end
    cso_next = (bn_reg == 4'h1) ? mux_d_reg : (bcnt_reg < (bn_reg >> 1));
    // Stopped source parks the output low, else a divided high phase would hang
    if (stop_mode && !mux_d_reg)
      cso_next = 1'b0;
    bus_next = (cso_next && !cso_reg) ? ~bus_reg : bus_reg;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bcnt_reg <= '0;
      bn_reg   <= 4'h1;
      cso_reg  <= 1'b0;
      bus_reg  <= 1'b0;
    end else begin
      bcnt_reg <= bcnt_next;
      bn_reg   <= bn_next;
      cso_reg  <= cso_next;
      bus_reg  <= bus_next;
    end
  end

  always_comb begin
    logic irc_want, erc_want;
    // Reference gates update only while the reference is low
    irc_want = cfg.internal_ref_enable &&
               (!stop_mode || cfg.internal_ref_stop_enable);
    erc_want = cfg.external_ref_enable &&
               (!stop_mode || cfg.external_ref_stop_enable);
    irc_gate_next = int_d_reg ? irc_gate_reg : irc_want;
    erc_gate_next = ext_d_reg ? erc_gate_reg : erc_want;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irc_gate_reg <= 1'b0;
      erc_gate_reg <= 1'b0;
    end else begin
      irc_gate_reg <= irc_gate_next;
      erc_gate_reg <= erc_gate_next;
    end
  end

  always_comb begin
    // Free-running low-power oscillator
    lpo_cnt_next = lpo_cnt_reg + 1'b1;
    lpo_next     = lpo_reg;
    if (lpo_cnt_reg >= LPO_W'(LPO_HALF - 1)) begin
      lpo_cnt_next = '0;
      lpo_next     = ~lpo_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lpo_cnt_reg <= '0;
      lpo_reg     <= 1'b0;
    end else begin
      lpo_cnt_reg <= lpo_cnt_next;
      lpo_reg     <= lpo_next;
    end
  end

  always_comb begin
    out_next.clock_source_output      = cso_reg;
    out_next.bus_clock                = bus_reg;
    out_next.internal_reference_clock = int_d_reg & irc_gate_reg;
    out_next.external_reference_clock = ext_d_reg & erc_gate_reg;
    out_next.fixed_frequency_clock    = loop_in_reg;
    out_next.oscillator_passthrough   = ext_s2_reg;
    out_next.low_power_oscillator     = lpo_reg;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_out           <= '0;
      loop_ref_external <= 1'b0;
    end else begin
      clk_out           <= out_next;
      loop_ref_external <= ref_ext_reg;
    end
  end

endmodule : csu_clock_source_unit

// file: include/csu_pkg.sv
/*
  Constants, configuration and clock-bundle types of the clock source unit.
  Assumes a single 20 MHz system clock samples every reference clock.
*/
package csu_pkg;

  localparam int unsigned SYS_FREQ_HZ    = 20_000_000;
  localparam int unsigned LPO_FREQ_HZ    = 1_000;
  localparam int unsigned LPO_HALF_CYC   = SYS_FREQ_HZ / (2 * LPO_FREQ_HZ);
  localparam int unsigned FLL_MAX_HZ     = 50_000_000;
  localparam int unsigned FLL_OUT_MAX_HZ = (SYS_FREQ_HZ / 2 < FLL_MAX_HZ) ?
                                           SYS_FREQ_HZ / 2 : FLL_MAX_HZ;

  localparam int unsigned REFERENCE_DIVIDER_W   = 11;
  localparam int unsigned REFERENCE_DIVIDER_MAX = 1024;
  localparam int unsigned MULT_W   = 10;
  localparam int unsigned PER_W    = 16;
  localparam int unsigned LPO_W    = 16;

  localparam logic [REFERENCE_DIVIDER_W-1:0] REFERENCE_DIVIDER_RESET = 11'h001;
  localparam logic [MULT_W-1:0] MULT_RESET = 10'h001;

  typedef enum logic [1:0] {
    BUS_FREQUENCY_DIVIDER_1,
    BUS_FREQUENCY_DIVIDER_2,
    BUS_FREQUENCY_DIVIDER_4,
    BUS_FREQUENCY_DIVIDER_8
  } csu_bus_frequency_divider_t;

  typedef struct packed {
    logic              ref_external;
    logic [REFERENCE_DIVIDER_W-1:0] ref_divider;
    logic [MULT_W-1:0] loop_mult;
    logic              loop_bypass;
    csu_bus_frequency_divider_t         bus_divider;
    logic              internal_ref_enable;
    logic              external_ref_enable;
    logic              internal_ref_stop_enable;
    logic              external_ref_stop_enable;
  } csu_cfg_t;

  typedef struct packed {
    logic clock_source_output;
    logic bus_clock;
    logic internal_reference_clock;
    logic external_reference_clock;
    logic fixed_frequency_clock;
    logic oscillator_passthrough;
    logic low_power_oscillator;
  } csu_clk_t;

endpackage : csu_pkg

// file: testbench/csu_clock_source_unit_props.sv
/*
  Concurrent checks on the clock source unit ports.
  Assumes one clk_sys domain; bound into every unit instance below.
*/
`timescale 1ns/1ps
module csu_clock_source_unit_props #(
  parameter int unsigned LPO_HALF = 4
) (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              ext_ref_pin,
  input wire logic              int_ref_pin,
  input wire logic              stop_mode,
  input wire csu_pkg::csu_cfg_t cfg,
  input wire csu_pkg::csu_clk_t clk_out,
  input wire logic              loop_ref_external
);
  import csu_pkg::*;
  logic [2:0]  up_reg;
  int unsigned lc_reg;
  logic        lpo_q_reg;
  logic        lseen_reg;
  wire logic   lpo_edge = clk_out.low_power_oscillator != lpo_q_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // First low-power phase after reset has no reference point, so it is skipped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_reg    <= 3'h0;
      lc_reg    <= 0;
      lpo_q_reg <= 1'h0;
      lseen_reg <= 1'h0;
    end else begin
      if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
      lpo_q_reg <= clk_out.low_power_oscillator;
      lc_reg    <= lpo_edge ? 0 : lc_reg + 1;
      if (lpo_edge) lseen_reg <= 1'h1;
    end
  end
  sequence s_to_ext;
    $rose(cfg.ref_external);
  endsequence
  chk_pass_delay: assert property (up_reg == 3'h7 |->
    clk_out.oscillator_passthrough == $past(ext_ref_pin, 4)) else $error("passthrough lag");
  chk_bus_toggle: assert property ($rose(clk_out.clock_source_output) |->
    ##[0:1] $changed(clk_out.bus_clock)) else $error("bus clock not halved");
  chk_stop_low: assert property (stop_mode [*5] |->
    !clk_out.clock_source_output) else $error("source runs in stop");
  chk_stop_hold: assert property (stop_mode [*5] |->
    $stable(clk_out.bus_clock)) else $error("bus clock moves in stop");
  chk_int_gate: assert property (!cfg.internal_ref_enable [*8] |->
    !clk_out.internal_reference_clock) else $error("internal gate open");
  chk_int_stop: assert property ((stop_mode && !cfg.internal_ref_stop_enable) [*8] |->
    !clk_out.internal_reference_clock) else $error("internal runs in stop");
  chk_lpo_half: assert property (lpo_edge && lseen_reg |->
    lc_reg == LPO_HALF - 1) else $error("low-power half period");
  chk_lpo_run: assert property (lc_reg <= LPO_HALF + 2) else $error("low-power stuck");
  chk_sel_ext: assert property (s_to_ext |-> ##[1:60] loop_ref_external)
    else $error("external select late");
endmodule : csu_clock_source_unit_props

bind csu_clock_source_unit csu_clock_source_unit_props #(.LPO_HALF(LPO_HALF)) i_props (
  .clk_sys(clk_sys), .nrst(nrst), .ext_ref_pin(ext_ref_pin), .int_ref_pin(int_ref_pin),
  .stop_mode(stop_mode), .cfg(cfg), .clk_out(clk_out), .loop_ref_external(loop_ref_external));

// file: testbench/csu_consumer.sv
/*
  Far-side model: core and peripherals counting the clocks they receive.
  Assumes clock levels are sampled on clk_sys.
*/
`timescale 1ns/1ps
module csu_consumer (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire csu_pkg::csu_clk_t clks,
  output int                    n_cso,
  output int                    n_bus
);
  import csu_pkg::*;
  logic cso_q;
  logic bus_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {cso_q, bus_q, n_cso, n_bus} <= '0;
    end else begin
      cso_q <= clks.clock_source_output;
      bus_q <= clks.bus_clock;
      if (clks.clock_source_output && !cso_q) n_cso <= n_cso + 1;
      if (clks.bus_clock && !bus_q) n_bus <= n_bus + 1;
    end
  end
endmodule : csu_consumer

// file: testbench/clock_source_selector_tb.sv
/*
  Self-checking bench: rate counts against expected periods.
  Assumes the package, the unit and the consumer model are compiled first.
*/
`timescale 1ns/1ps
module clock_source_selector_tb;
  import csu_pkg::*;
  logic     clk_sys = 1'h0;
  logic     nrst = 1'h0;
  logic     ext_ref_pin = 1'h0;
  logic     int_ref_pin = 1'h0;
  logic     stop_mode = 1'h0;
  csu_cfg_t cfg;
  csu_clk_t clk_out;
  logic     loop_ref_external;
  int       n_cso, n_bus, tick = 0, n_fail = 0, tests_run = 0;
  int       cnt [7];
  int       q_div [$];
  csu_clock_source_unit #(.LPO_HALF(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .ext_ref_pin(ext_ref_pin), .int_ref_pin(int_ref_pin), .stop_mode(stop_mode),
    .cfg(cfg), .clk_out(clk_out), .loop_ref_external(loop_ref_external));
  csu_consumer i_cons (.clk_sys(clk_sys), .nrst(nrst), .clks(clk_out), .n_cso(n_cso),
    .n_bus(n_bus));
  always #25 clk_sys = ~clk_sys;
  // Scaled references: external period 4 cycles, internal 6
  always @(posedge clk_sys) begin
    tick <= tick + 1;
    if (tick % 2 == 1) ext_ref_pin <= ~ext_ref_pin;
    if (tick % 3 == 2) int_ref_pin <= ~int_ref_pin;
  end
  task automatic chk(input string nm, input int exp, input int got, input int tol);
    tests_run++;
    if (got > exp + tol || got < exp - tol) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk
  task automatic measure(input int settle, input int w);
    logic [6:0] pv;
    repeat (settle) @(posedge clk_sys);
    pv = clk_out;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (w) begin
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 7; i++) if (clk_out[i] && !pv[i]) cnt[i]++;
      pv = clk_out;
    end
    @(posedge clk_sys);
  endtask : measure
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    #3_000_000;
    n_fail++;
    close_out();
  end
  initial begin
    int bd [4];
    int s0;
    int b0;
    bd = '{1, 2, 4, 8};
    cfg = '0;
    cfg.loop_bypass = 1'h1;
    cfg.ref_divider = 11'h001;
    cfg.loop_mult = 10'h001;
    {cfg.internal_ref_enable, cfg.external_ref_enable} = 2'h3;
    {cfg.internal_ref_stop_enable, cfg.external_ref_stop_enable} = 2'h3;
    void'($urandom(4));
    repeat (4) @(posedge clk_sys);
    chk("reset_out", 1, int'(clk_out === 7'h00), 0);
    nrst <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      cfg.bus_divider <= csu_bus_frequency_divider_t'(k);
      repeat (150) @(posedge clk_sys);
      s0 = n_cso;
      b0 = n_bus;
      measure(0, 480);
      chk("cso_rate", 480 / (6 * bd[k]), cnt[6], 1);
      chk("ffc_int", 80, cnt[2], 1);
      chk("bus_half", (n_cso - s0) / 2, n_bus - b0, 1);
    end
    $display("bus divider test done");
    cfg.bus_divider <= BUS_FREQUENCY_DIVIDER_1;
    cfg.loop_bypass <= 1'h0;
    // Scaled loop input stands for the legal reference window
    cfg.loop_mult <= 10'h002;
    measure(250, 480);
    chk("loop_rate", 160, cnt[6], 3);
    $display("loop test done");
    cfg.loop_bypass <= 1'h1;
    cfg.ref_external <= 1'h1;
    q_div = '{1, 2 + $urandom % 7, 3, 1024};
    foreach (q_div[i]) begin
      cfg.ref_divider <= 11'(q_div[i]);
      measure(8 * q_div[i] + 60, 32 * q_div[i]);
      chk("ffc_div", 8, cnt[2], 1);
      chk("cso_ext", 8, cnt[6], 1);
      chk("pass", 8 * q_div[i], cnt[1], 1);
    end
    $display("reference divider test done");
    stop_mode <= 1'h1;
    cfg.internal_ref_stop_enable <= 1'h0;
    measure(20, 120);
    chk("stop_cso", 0, cnt[6], 0);
    chk("stop_int", 0, cnt[4], 0);
    chk("stop_ext", 30, cnt[3], 1);
    chk("lpo", 15, cnt[0], 1);
    $display("stop test done");
    stop_mode <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      cfg.internal_ref_enable <= 1'(k);
      cfg.external_ref_enable <= 1'(1 - k);
      measure(20, 120);
      chk("int_gate", 20 * k, cnt[4], 1);
      chk("ext_gate", 30 * (1 - k), cnt[3], 1);
    end
    $display("enable test done");
    close_out();
  end
endmodule : clock_source_selector_tb
